// ---- hw/pic_consts.svh ----
// Timing counts, stage indices and widths of the pipeline interlock block.
// Assumes it is included by bare name from the package and the design modules.
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// ------------------------
// Clock and pipeline cycle timing
// ------------------------
`define PIC_CLK_NS          40
`define PIC_PIPE_CYCLE_NS   250
`define PIC_PIPE_CLKS       ((`PIC_PIPE_CYCLE_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`define PIC_TICK_W          3
`define PIC_TICK_LAST       3'(`PIC_PIPE_CLKS - 1)

// ------------------------
// Stage indices: fetch, instruction translate, address, operand translate,
// operand read, compute
// ------------------------
`define PIC_STG_FETCH       0
`define PIC_STG_IXLATE      1
`define PIC_STG_EA          2
`define PIC_STG_OXLATE      3
`define PIC_STG_OREAD       4
`define PIC_STG_COMPUTE     5

// ------------------------
// Widths and counts
// ------------------------
`define PIC_ADDR_W          16
`define PIC_REG_W           4
`define PIC_NCYC_W          4
`define PIC_CMP_BITS        15
`define PIC_STORE_WR_CYCLES 2'd2
`define PIC_NCYC_ONE        4'h1

`endif

// ---- hw/pic_pkg.sv ----
// Types shared by the pipeline interlock modules.
// Assumes pic_consts.svh is on the include path.
`include "pic_consts.svh"

package pic_pkg;

   // Instruction class carried by each stage token, one-hot.
   typedef enum logic [7:0] {
      KIND_NONE              = 8'h01,
      KIND_LOAD              = 8'h02,
      KIND_BRANCH            = 8'h04,
      KIND_STORE_OTHER       = 8'h08,
      KIND_WORD_WRITE_INSTR  = 8'h10,
      KIND_HALF_WRITE_INSTR  = 8'h20,
      KIND_FLOAT_WRITE_INSTR = 8'h40,
      KIND_BYTE_WRITE_INSTR  = 8'h80
   } pic_kind_e;

   typedef logic [`PIC_ADDR_W-1:0] pic_addr_t;
   typedef logic [`PIC_REG_W-1:0]  pic_reg_t;
   typedef logic [`PIC_NCYC_W-1:0] pic_ncyc_t;

   // True only for the four simple store classes.
   function automatic logic pic_is_simple_store(input pic_kind_e k);
      pic_is_simple_store = (k == KIND_WORD_WRITE_INSTR) || (k == KIND_HALF_WRITE_INSTR) ||
                            (k == KIND_FLOAT_WRITE_INSTR) || (k == KIND_BYTE_WRITE_INSTR);
   endfunction : pic_is_simple_store

endpackage : pic_pkg

// ---- hw/pic_addr_cmp.sv ----
// Store conflict address comparator.
// Assumes both addresses are 16-bit logical addresses; purely combinational.
`include "pic_consts.svh"

module pic_addr_cmp
   import pic_pkg::*;
(
   // Addresses compared
   input  wire pic_addr_t store_addr,
   input  wire pic_addr_t load_addr,
   // Result
   output logic           hit
);

   // ------------------------
   // Adjacency on the low address bits, wrapping at the top of the field
   // ------------------------

   // Every access spans two locations, so equal or one apart is a hit.
   function automatic logic near(input logic [`PIC_CMP_BITS-1:0] a, input logic [`PIC_CMP_BITS-1:0] b);
      logic [`PIC_CMP_BITS-1:0] d;
      d    = a - b;
      near = (d == '0) || (d == `PIC_CMP_BITS'(1)) || (d == '1);
   endfunction : near

   // Only the low bits are compared, never a translated address.
   assign hit = near(store_addr[`PIC_CMP_BITS-1:0], load_addr[`PIC_CMP_BITS-1:0]);

endmodule : pic_addr_cmp

// ---- hw/pic_reg_hazard.sv ----
// Base/index register conflict detector for the address stage.
// Assumes writers in the three stages downstream of the address stage are given.
`include "pic_consts.svh"

module pic_reg_hazard
   import pic_pkg::*;
(
   // Reader in the address stage
   input  wire logic     ea_valid,
   input  wire logic     ea_bx_use,
   input  wire pic_reg_t ea_base,
   input  wire pic_reg_t ea_index,
   // Writers downstream
   input  wire logic     ox_wr,
   input  wire pic_reg_t ox_wr_reg,
   input  wire logic     of_wr,
   input  wire pic_reg_t of_wr_reg,
   input  wire logic     ex_wr,
   input  wire pic_reg_t ex_wr_reg,
   // Result
   output logic          conflict
);

   // Writer w with target t collides with either address register.
   function automatic logic clash(input logic w, input pic_reg_t t, input pic_reg_t b, input pic_reg_t x);
      clash = w && ((t == b) || (t == x));
   endfunction : clash

   // Only instructions forming an address from base or index are checked.
   assign conflict = ea_valid && ea_bx_use &&
                     (clash(ox_wr, ox_wr_reg, ea_base, ea_index) ||
                      clash(of_wr, of_wr_reg, ea_base, ea_index) ||
                      clash(ex_wr, ex_wr_reg, ea_base, ea_index));

endmodule : pic_reg_hazard

// ---- hw/pic_pipeline_interlock_control.sv ----
// Interlock and restart control for a six-stage prefetching pipeline.
// Assumes a fetch source that decodes tokens and offers a branch target
// right after a restart, and a memory side taking operand reads and writes.
// Functional notes
// - Six independent stages: fetch, translate, address, operand translate, read, compute.
// - Pipeline advances once per seven-clock pipeline cycle, 280 ns at the 40 ns clock.
// - A taken branch discards all prefetched work and restarts at target.
// - A taken-branch restart leaves the compute stage idle exactly three cycles.
// - The address stage takes the prefetched target first to shorten restart.
// - A branch not taken keeps all prefetched work, no restart.
// - Register conflicts checked only for base or index address forming.
// - Conflict when any of three older instructions writes that register.
// - Address stage holds until written; stall 3, 2 or 1 cycles.
// - Each address-stage conflict stall shows as one compute idle cycle.
// - Multi-cycle instructions hold address work until their last compute cycle.
// - A simple store uses two extra memory cycles to write.
// - Address stage pre-reads the store target for protection checking.
// - A store costs at most two compute cycles, depending on follower.
// - Store handling applies to word, half, float and byte stores only.
// - A load hitting an outstanding store write waits until it completes.
// - The early conflicting operand read is done but its data discarded.
// - Store conflicts are checked only against pending simple stores.
// - Accesses cover two locations; addresses at most one apart conflict.
// - Compare only low fifteen logical address bits, never physical ones.
// - 7FFF is adjacent to 0000 and FFFF adjacent to 8000.
// - Store conflict delay: two cycles, one cycle, then none.
// - One pending-store register, so one simple store in flight.
// - Second store waits: two cycles, one cycle, then none.
// - Second-store wait is an address-stage hold, never a restart.
`include "pic_consts.svh"

module pic_pipeline_interlock_control
   import pic_pkg::*;
(
   // Clock, reset and enable
   input  wire logic      clk,
   input  wire logic      rst,
   input  wire logic      ce,
   // Fetch port, one decoded token per accepted transfer
   input  wire logic      fetch_valid,
   output logic           fetch_ready,
   input  wire pic_kind_e fetch_kind,
   input  wire logic      fetch_bx_use,
   input  wire pic_reg_t  fetch_base_reg,
   input  wire pic_reg_t  fetch_index_reg,
   input  wire logic      fetch_wr_en,
   input  wire pic_reg_t  fetch_wr_reg,
   input  wire pic_addr_t fetch_addr,
   input  wire pic_ncyc_t fetch_ncyc,
   // Branch outcome for the compute stage
   input  wire logic      branch_taken,
   // Pipeline cycle and restart
   output logic           pipe_tick,
   output logic           restart,
   output pic_addr_t      restart_addr,
   output logic           redirect_wait,
   // Store protection pre-read
   output logic           ea_preread,
   output pic_addr_t      ea_addr,
   // Operand read
   output logic           opnd_rd,
   output pic_addr_t      opnd_addr,
   output logic           opnd_discard,
   // Memory write of the pending store
   output logic           mem_wr,
   output logic           mem_wr_first,
   output pic_addr_t      mem_wr_addr,
   // Register write-back
   output logic           reg_wr,
   output pic_reg_t       reg_wr_idx,
   // Stage status
   output logic           ex_idle,
   output logic           stall_long,
   output logic           stall_reg,
   output logic           stall_store_ser,
   output logic           stall_store_cfl
);

   localparam int NST = 6;
   // ------------------------
   // Declarations
   // ------------------------
   logic [`PIC_TICK_W-1:0] tick_q;
   logic                   adv;
   // Stage tokens, indexed by stage number.
   logic      valid_q [0:NST-1];
   pic_kind_e kind_q  [0:NST-1];
   logic      bx_q    [0:NST-1];
   pic_reg_t  base_q  [0:NST-1];
   pic_reg_t  idx_q   [0:NST-1];
   logic      wen_q   [0:NST-1];
   pic_reg_t  wreg_q  [0:NST-1];
   pic_addr_t addr_q  [0:NST-1];
   pic_ncyc_t ncyc_q  [0:NST-1];
   // Source of each stage's next token.
   logic      s_valid [0:NST-1];
   pic_kind_e s_kind  [0:NST-1];
   logic      s_bx    [0:NST-1];
   pic_reg_t  s_base  [0:NST-1];
   pic_reg_t  s_idx   [0:NST-1];
   logic      s_wen   [0:NST-1];
   pic_reg_t  s_wreg  [0:NST-1];
   pic_addr_t s_addr  [0:NST-1];
   pic_ncyc_t s_ncyc  [0:NST-1];
   logic [NST-1:0] hold, take;
   pic_ncyc_t      ex_cnt_q;
   logic           ex_last, flush, redirect_q, fetch_acc;
   logic           restart_q;
   pic_addr_t      restart_addr_q;
   logic [1:0]     pend_cnt_q;
   pic_addr_t      pend_addr_q;
   logic           reg_cfl, ser_hold, of_load, hit_ex, hit_pend, of_cfl;

   // ------------------------
   // Pipeline cycle timing
   // ------------------------
   // Divides the clock down to one pipeline cycle; all stages move on it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q <= '0;
      end else if (ce) begin
         tick_q <= (tick_q == `PIC_TICK_LAST) ? '0 : tick_q + 3'h1;
      end
   end
   assign pipe_tick = (tick_q == `PIC_TICK_LAST);
   assign adv       = ce && pipe_tick;

   // ------------------------
   // Stall detection
   // ------------------------
   // Base/index conflict against the three older stages.
   pic_reg_hazard u_reg_hazard (
      .ea_valid  (valid_q[`PIC_STG_EA]),
      .ea_bx_use (bx_q[`PIC_STG_EA]),
      .ea_base   (base_q[`PIC_STG_EA]),
      .ea_index  (idx_q[`PIC_STG_EA]),
      .ox_wr     (valid_q[`PIC_STG_OXLATE] && wen_q[`PIC_STG_OXLATE]),
      .ox_wr_reg (wreg_q[`PIC_STG_OXLATE]),
      .of_wr     (valid_q[`PIC_STG_OREAD] && wen_q[`PIC_STG_OREAD]),
      .of_wr_reg (wreg_q[`PIC_STG_OREAD]),
      .ex_wr     (valid_q[`PIC_STG_COMPUTE] && wen_q[`PIC_STG_COMPUTE]),
      .ex_wr_reg (wreg_q[`PIC_STG_COMPUTE]),
      .conflict  (reg_cfl)
   );

   // Store conflict against the simple store now computing.
   pic_addr_cmp u_cmp_ex (
      .store_addr (addr_q[`PIC_STG_COMPUTE]),
      .load_addr  (addr_q[`PIC_STG_OREAD]),
      .hit        (hit_ex)
   );

   // Store conflict against the store whose write has just begun.
   pic_addr_cmp u_cmp_pend (
      .store_addr (pend_addr_q),
      .load_addr  (addr_q[`PIC_STG_OREAD]),
      .hit        (hit_pend)
   );

   // A second simple store waits while the first is in translate or read.
   assign ser_hold = valid_q[`PIC_STG_EA] && pic_is_simple_store(kind_q[`PIC_STG_EA]) &&
                     ((valid_q[`PIC_STG_OXLATE] && pic_is_simple_store(kind_q[`PIC_STG_OXLATE])) ||
                      (valid_q[`PIC_STG_OREAD] && pic_is_simple_store(kind_q[`PIC_STG_OREAD])));

   // A load conflicts while the matching write is not yet completed.
   assign of_load = valid_q[`PIC_STG_OREAD] && (kind_q[`PIC_STG_OREAD] == KIND_LOAD);
   assign of_cfl  = of_load &&
                    ((valid_q[`PIC_STG_COMPUTE] && pic_is_simple_store(kind_q[`PIC_STG_COMPUTE]) && hit_ex) ||
                     ((pend_cnt_q == `PIC_STORE_WR_CYCLES) && hit_pend));

   // Multi-cycle compute holds every stage behind it.
   assign ex_last = (ex_cnt_q <= `PIC_NCYC_ONE);

   // Holds ripple upstream so no younger token passes an older one.
   always_comb begin
      hold[`PIC_STG_COMPUTE] = valid_q[`PIC_STG_COMPUTE] && !ex_last;
      hold[`PIC_STG_OREAD]   = hold[`PIC_STG_COMPUTE] || of_cfl;
      hold[`PIC_STG_OXLATE]  = hold[`PIC_STG_OREAD];
      hold[`PIC_STG_EA]      = hold[`PIC_STG_OXLATE] || reg_cfl || ser_hold;
      hold[`PIC_STG_IXLATE]  = hold[`PIC_STG_EA];
      hold[`PIC_STG_FETCH]   = hold[`PIC_STG_IXLATE];
   end

   // A stage takes its upstream token only if that stage is moving.
   always_comb begin
      take[0] = 1'b1;
      for (int i = 1; i < NST; i++) begin
         take[i] = !hold[i-1];
      end
      if (redirect_q) begin
         take[`PIC_STG_OXLATE] = 1'b1;
      end
   end

   // ------------------------
   // Branch restart
   // ------------------------
   // Restart only when a branch ends computing with its condition met.
   assign flush = valid_q[`PIC_STG_COMPUTE] && (kind_q[`PIC_STG_COMPUTE] == KIND_BRANCH) &&
                  ex_last && branch_taken;

   // After restart the fetch side offers the prefetched target, which the
   // address stage hands straight to operand translate.
   assign fetch_ready = adv && !flush && (redirect_q ? !hold[`PIC_STG_OXLATE] : !hold[`PIC_STG_FETCH]);
   assign fetch_acc   = fetch_valid && fetch_ready;

   // Waits for the target token, which leaves the compute stage idle for three cycles.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         redirect_q <= 1'b0;
      end else if (adv) begin
         if (flush) begin
            redirect_q <= 1'b1;
         end else if (fetch_acc) begin
            redirect_q <= 1'b0;
         end
      end
   end

   // One-clock restart pulse carrying the branch target.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         restart_q      <= 1'b0;
         restart_addr_q <= '0;
      end else if (ce) begin
         restart_q <= adv && flush;
         if (adv && flush) begin
            restart_addr_q <= addr_q[`PIC_STG_COMPUTE];
         end
      end
   end
   assign restart       = restart_q;
   assign restart_addr  = restart_addr_q;
   assign redirect_wait = redirect_q;

   // ------------------------
   // Stage sources and token movement
   // ------------------------
   // Fetch feeds stage 0, or operand translate while a target is awaited.
   always_comb begin
      for (int i = 0; i < NST; i++) begin
         if (i == `PIC_STG_FETCH || (i == `PIC_STG_OXLATE && redirect_q)) begin
            s_valid[i] = fetch_acc && (i == `PIC_STG_OXLATE) == redirect_q;
            s_kind[i]  = fetch_kind;
            s_bx[i]    = fetch_bx_use;
            s_base[i]  = fetch_base_reg;
            s_idx[i]   = fetch_index_reg;
            s_wen[i]   = fetch_wr_en;
            s_wreg[i]  = fetch_wr_reg;
            s_addr[i]  = fetch_addr;
            s_ncyc[i]  = fetch_ncyc;
         end else begin
            s_valid[i] = valid_q[i-1];
            s_kind[i]  = kind_q[i-1];
            s_bx[i]    = bx_q[i-1];
            s_base[i]  = base_q[i-1];
            s_idx[i]   = idx_q[i-1];
            s_wen[i]   = wen_q[i-1];
            s_wreg[i]  = wreg_q[i-1];
            s_addr[i]  = addr_q[i-1];
            s_ncyc[i]  = ncyc_q[i-1];
         end
      end
   end

   // Each stage holds its own token; a moving stage with a stalled source
   // takes a bubble, and a restart empties all stages ahead of compute.
   generate
      for (genvar g = 0; g < NST; g++) begin : g_stage
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               valid_q[g] <= 1'b0;
               kind_q[g]  <= KIND_NONE;
               bx_q[g]    <= 1'b0;
               base_q[g]  <= '0;
               idx_q[g]   <= '0;
               wen_q[g]   <= 1'b0;
               wreg_q[g]  <= '0;
               addr_q[g]  <= '0;
               ncyc_q[g]  <= '0;
            end else if (adv) begin
               if (flush && g != `PIC_STG_COMPUTE) begin
                  valid_q[g] <= 1'b0;
               end else if (!hold[g]) begin
                  valid_q[g] <= take[g] && s_valid[g] && !flush;
                  kind_q[g]  <= s_kind[g];
                  bx_q[g]    <= s_bx[g];
                  base_q[g]  <= s_base[g];
                  idx_q[g]   <= s_idx[g];
                  wen_q[g]   <= s_wen[g];
                  wreg_q[g]  <= s_wreg[g];
                  addr_q[g]  <= s_addr[g];
                  ncyc_q[g]  <= s_ncyc[g];
               end
            end
         end
      end
   endgenerate

   // Counts the remaining compute cycles of the token in the compute stage.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ex_cnt_q <= '0;
      end else if (adv) begin
         if (!hold[`PIC_STG_COMPUTE]) begin
            ex_cnt_q <= s_ncyc[`PIC_STG_COMPUTE];
         end else begin
            ex_cnt_q <= ex_cnt_q - `PIC_NCYC_ONE;
         end
      end
   end

   // ------------------------
   // Pending store register and memory write
   // ------------------------
   // A simple store leaving compute claims the single pending register
   // for its two write cycles.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_cnt_q  <= '0;
         pend_addr_q <= '0;
      end else if (adv) begin
         if (valid_q[`PIC_STG_COMPUTE] && pic_is_simple_store(kind_q[`PIC_STG_COMPUTE]) &&
             !hold[`PIC_STG_COMPUTE]) begin
            pend_cnt_q  <= `PIC_STORE_WR_CYCLES;
            pend_addr_q <= addr_q[`PIC_STG_COMPUTE];
         end else if (pend_cnt_q != '0) begin
            pend_cnt_q <= pend_cnt_q - 2'd1;
         end
      end
   end

   // Write strobes, one per write cycle of the pending store.
   assign mem_wr       = adv && (pend_cnt_q != '0);
   assign mem_wr_first = adv && (pend_cnt_q == `PIC_STORE_WR_CYCLES);
   assign mem_wr_addr  = pend_addr_q;

   // ------------------------
   // Memory reads and register write-back
   // ------------------------
   // A simple store reads its target while computing its address so that
   // protection faults surface before the write.
   assign ea_preread = adv && valid_q[`PIC_STG_EA] && pic_is_simple_store(kind_q[`PIC_STG_EA]) &&
                       !hold[`PIC_STG_EA];
   assign ea_addr    = addr_q[`PIC_STG_EA];

   // The operand read goes out even under a conflict, but is marked discarded.
   assign opnd_rd      = adv && of_load;
   assign opnd_addr    = addr_q[`PIC_STG_OREAD];
   assign opnd_discard = adv && of_cfl;

   // Register write at the last compute cycle releases address-stage waiters.
   assign reg_wr     = adv && valid_q[`PIC_STG_COMPUTE] && wen_q[`PIC_STG_COMPUTE] && ex_last;
   assign reg_wr_idx = wreg_q[`PIC_STG_COMPUTE];

   // ------------------------
   // Status
   // ------------------------
   // Level indications of the compute bubble and of each stall cause.
   assign ex_idle         = !valid_q[`PIC_STG_COMPUTE];
   assign stall_long      = hold[`PIC_STG_COMPUTE];
   assign stall_reg       = reg_cfl;
   assign stall_store_ser = ser_hold;
   assign stall_store_cfl = of_cfl;

endmodule : pic_pipeline_interlock_control

// ---- testbench/pic_ilk_props.sv ----
// Port assertions for the pipeline interlock block.
// Assumes ce stays high while the block is watched.
module pic_ilk_props
   import pic_pkg::*;
(
   // Watched ports
   input wire logic clk, rst, pipe_tick, fetch_ready, restart, redirect_wait, ex_idle,
   input wire logic mem_wr, mem_wr_first, opnd_rd, opnd_discard, ea_preread
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Ticks, restart and memory strobes are tied to their causes.
   property p_tick_gap; pipe_tick |=> !pipe_tick [*6] ##1 pipe_tick; endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
   property p_ready; fetch_ready |-> pipe_tick; endproperty
   a_ready: assert property (p_ready) else $error("ready off tick");
   property p_rst_pulse; restart |=> !restart; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("restart too long");
   property p_rst_wait; restart |-> redirect_wait; endproperty
   a_rst_wait: assert property (p_rst_wait) else $error("no redirect wait");
   property p_rst_idle; restart |-> ex_idle [*8] ##7 ex_idle ##7 !ex_idle; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("compute busy in restart");
   property p_wr_pair; mem_wr_first |=> !mem_wr [*6] ##1 (mem_wr && !mem_wr_first); endproperty
   a_wr_pair: assert property (p_wr_pair) else $error("second write missing");
   property p_wr_first; mem_wr_first |-> mem_wr && pipe_tick; endproperty
   a_wr_first: assert property (p_wr_first) else $error("first write bad");
   property p_discard; opnd_discard |-> opnd_rd; endproperty
   a_discard: assert property (p_discard) else $error("discard without read");
   property p_preread; ea_preread |-> pipe_tick && !$past(ea_preread); endproperty
   a_preread: assert property (p_preread) else $error("pre-read off tick");
endmodule : pic_ilk_props

// ---- testbench/pic_mem_model.sv ----
// Memory and translation side model: logs writes, discarded reads, pre-reads, restarts and stalls.
// Assumes write, discard, pre-read and restart strobes are one-clock pulses; the stall inputs are levels counted per clock.
module pic_mem_model
   import pic_pkg::*;
(
   // Clock and clear
   input  logic      clk, clr,
   // Strobes from the block
   input  logic      mem_wr, opnd_discard, ea_preread, restart, stall_reg, stall_store_ser, stall_long,
   input  pic_addr_t mem_wr_addr, restart_addr,
   // Logged activity
   output int        nw, nd, np, nr, ng, ns, nl,
   output pic_addr_t lw, lr
);
   // Every access is taken at once; a discarded read is only counted.
   always_ff @(posedge clk) begin
      if (clr) begin
         {nw, nd, np, nr, ng, ns, nl} <= '0;
      end else begin
         if (mem_wr) nw <= nw + 1;
         if (mem_wr) lw <= mem_wr_addr;
         if (opnd_discard) nd <= nd + 1;
         if (ea_preread) np <= np + 1;
         if (restart) nr <= nr + 1;
         if (restart) lr <= restart_addr;
         if (stall_reg) ng <= ng + 1;
         if (stall_store_ser) ns <= ns + 1;
         if (stall_long) nl <= nl + 1;
      end
   end
endmodule : pic_mem_model

// ---- testbench/pipeline_interlock_control_tb.sv ----
// Self-checking bench for the pipeline interlock block.
// Assumes the memory model and the checker are compiled before it.
module pipeline_interlock_control_tb import pic_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, ce = 1, fetch_valid = 0, fetch_bx_use = 0, fetch_wr_en = 0, branch_taken = 0, clr = 0;
   pic_kind_e fetch_kind = KIND_NONE;
   pic_reg_t  fetch_base_reg = '0, fetch_index_reg = 4'he, fetch_wr_reg = '0, reg_wr_idx;
   pic_addr_t fetch_addr = '0, restart_addr, ea_addr, opnd_addr, mem_wr_addr, lw, lr;
   pic_ncyc_t fetch_ncyc = 4'h1;
   logic fetch_ready, pipe_tick, restart, redirect_wait, ea_preread, opnd_rd, opnd_discard, mem_wr;
   logic mem_wr_first, reg_wr, ex_idle, stall_long, stall_reg, stall_store_ser, stall_store_cfl;
   int bad_count = 0, cmp_count = 0, nw, nd, np, nr, ng, ns, nl;
   pic_pipeline_interlock_control uut (.clk, .rst, .ce, .fetch_valid, .fetch_ready, .fetch_kind, .fetch_bx_use,
      .fetch_base_reg, .fetch_index_reg, .fetch_wr_en, .fetch_wr_reg, .fetch_addr, .fetch_ncyc, .branch_taken,
      .pipe_tick, .restart, .restart_addr, .redirect_wait, .ea_preread, .ea_addr, .opnd_rd, .opnd_addr,
      .opnd_discard, .mem_wr, .mem_wr_first, .mem_wr_addr, .reg_wr, .reg_wr_idx, .ex_idle, .stall_long,
      .stall_reg, .stall_store_ser, .stall_store_cfl);
   pic_mem_model u_mem (.clk, .clr, .mem_wr, .opnd_discard, .ea_preread, .restart, .stall_reg, .stall_store_ser,
      .stall_long, .mem_wr_addr, .restart_addr, .nw, .nd, .np, .nr, .ng, .ns, .nl, .lw, .lr);
   // Free-running 25 MHz clock.
   initial forever #20 clk = ~clk;
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic chk_n(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         bad_count++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_n
   task automatic chk_a(input pic_addr_t got, input pic_addr_t exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t address %h expected %h", $time, got, exp);
      end
   endtask : chk_a
   // Offers one token and holds it until the edge that takes it.
   task automatic send(input pic_kind_e k, input logic b, input logic w, input pic_addr_t a);
      int i;
      i = 0;
      fetch_valid <= 1'b1;
      fetch_kind <= k;
      fetch_bx_use <= b;
      fetch_base_reg <= 4'h3;
      fetch_wr_en <= w;
      fetch_wr_reg <= 4'h3;
      fetch_addr <= a;
      do @(negedge clk); while (fetch_ready !== 1'b1 && ++i < 60);
      if (i == 60) chk_n(0, 1);
      @(posedge clk);
   endtask : send
   // Clears the log, sends two tokens apart by gap fillers, then drains.
   task automatic pair(input pic_kind_e k1, input logic w1, input pic_addr_t a1, input int gap,
                       input pic_kind_e k2, input logic b2, input pic_addr_t a2);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      send(k1, 1'b0, w1, a1);
      fetch_ncyc <= 4'h1;
      repeat (gap) send(KIND_NONE, 1'b0, 1'b0, 16'h0000);
      send(k2, b2, 1'b0, a2);
      repeat (8) send(KIND_NONE, 1'b0, 1'b0, 16'h0000);
      fetch_valid <= 1'b0;
      @(posedge clk);
   endtask : pair
   // Branch taken and not taken; the first filler accepted after the restart is the target.
   task automatic t_branch;
      branch_taken <= 1'b1;
      pair(KIND_BRANCH, 1'b0, 16'h1234, 0, KIND_NONE, 1'b0, 16'h0000);
      chk_n(nr, 1);
      chk_a(lr, 16'h1234);
      branch_taken <= 1'b0;
      pair(KIND_BRANCH, 1'b0, 16'h1234, 0, KIND_NONE, 1'b0, 16'h0000);
      chk_n(nr, 0);
   endtask : t_branch
   // Each store class: simple ones write twice after a pre-read.
   task automatic t_store;
      pic_kind_e ks[6] = '{KIND_WORD_WRITE_INSTR, KIND_HALF_WRITE_INSTR, KIND_FLOAT_WRITE_INSTR,
                          KIND_BYTE_WRITE_INSTR, KIND_STORE_OTHER, KIND_LOAD};
      for (int i = 0; i < 6; i++) begin
         pair(ks[i], 1'b0, 16'h0100, 0, KIND_NONE, 1'b0, 16'h0000);
         chk_n(nw, i < 4 ? 2 : 0);
         chk_n(np, i < 4);
         if (i < 4) chk_a(lw, 16'h0100);
      end
   endtask : t_store
   // Store then load: address wrap, window width and spacing.
   task automatic t_cfl;
      pair(KIND_WORD_WRITE_INSTR, 1'b0, 16'h7fff, 0, KIND_LOAD, 1'b0, 16'h0000);
      chk_n(nd, 2);
      pair(KIND_HALF_WRITE_INSTR, 1'b0, 16'hffff, 0, KIND_LOAD, 1'b0, 16'h8000);
      chk_n(nd, 2);
      pair(KIND_WORD_WRITE_INSTR, 1'b0, 16'h0100, 0, KIND_LOAD, 1'b0, 16'h0101);
      chk_n(nd, 2);
      pair(KIND_WORD_WRITE_INSTR, 1'b0, 16'h0100, 0, KIND_LOAD, 1'b0, 16'h0102);
      chk_n(nd, 0);
      pair(KIND_BYTE_WRITE_INSTR, 1'b0, 16'h8100, 0, KIND_LOAD, 1'b0, 16'h0100);
      chk_n(nd, 2);
      pair(KIND_WORD_WRITE_INSTR, 1'b0, 16'h0100, 1, KIND_LOAD, 1'b0, 16'h0100);
      chk_n(nd, 1);
      pair(KIND_WORD_WRITE_INSTR, 1'b0, 16'h0100, 2, KIND_LOAD, 1'b0, 16'h0100);
      chk_n(nd, 0);
      pair(KIND_STORE_OTHER, 1'b0, 16'h0100, 0, KIND_LOAD, 1'b0, 16'h0100);
      chk_n(nd, 0);
   endtask : t_cfl
   // Base register writer then user; back-to-back simple stores.
   task automatic t_reg;
      pair(KIND_LOAD, 1'b1, 16'h0200, 0, KIND_LOAD, 1'b1, 16'h0300);
      chk_n(ng, 3 * 7);
      pair(KIND_LOAD, 1'b1, 16'h0200, 0, KIND_LOAD, 1'b0, 16'h0300);
      chk_n(ng, 0);
      pair(KIND_LOAD, 1'b1, 16'h0200, 3, KIND_LOAD, 1'b1, 16'h0300);
      chk_n(ng, 0);
      pair(KIND_WORD_WRITE_INSTR, 1'b0, 16'h0100, 0, KIND_HALF_WRITE_INSTR, 1'b0, 16'h0400);
      chk_n(ns, 2 * 7);
      chk_n(nw, 4);
   endtask : t_reg
   // A three-cycle compute holds the stages behind it for two pipe cycles.
   task automatic t_long;
      fetch_ncyc <= 4'h3;
      pair(KIND_LOAD, 1'b0, 16'h0500, 0, KIND_NONE, 1'b0, 16'h0000);
      chk_n(nl, 2 * 7);
   endtask : t_long
   // Main sequence after ten reset cycles.
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_branch();
      t_store();
      t_cfl();
      t_reg();
      t_long();
      finish_test();
   end
   // Watchdog against a hung handshake.
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      finish_test();
   end
endmodule : pipeline_interlock_control_tb
bind pic_pipeline_interlock_control pic_ilk_props u_props (.clk, .rst, .pipe_tick, .fetch_ready, .restart,
   .redirect_wait, .ex_idle, .mem_wr, .mem_wr_first, .opnd_rd, .opnd_discard, .ea_preread);
